// [hdl/evtcs_pkg.sv]
// Functional notes
// R1: Count range bottom zero, maximum all ones.
// R2: Clock select picks prescaler tap or companion.
// R3: Compare output enable drives waveform pin.
// R4: Enable starts counting on selected ticks.
// R5: Periodic mode counts to compare, flags, restarts.
// R6: Compare below count wraps through maximum.
// R7: Time-out mode starts and stops on edges.
// R8: Time-out reaching compare raises flag, event.
// R9: Frozen after stop; reads, run writes ignored.
// R10: Capture mode runs free, captures on edge.
// R11: Capture modes clear flag on low read.
// R12: Software zeroes count entering capture mode.
// R13: Frequency mode captures and restarts per edge.
// R14: Pulse-width restarts on rise, captures on fall.
// R15: Source keeps edges two clocks apart.
// R16: Combined mode: start, capture on fall, stop.
// R17: Software reads count before capture value.
// R18: Single-shot output low idle, high while running.
// R19: Single-shot stops, low one tick, ignores triggers.
// R20: Single-shot output rises two clocks after event; the code raises the pin five clocks after the detected edge.
// R21: Edge bit one: both edges; zero: rising.
// R22: Single-shot counts on enable without trigger.
// R23: Events act only with event input enable.
// R24: Interrupt while flag and enable both set; the code keeps the request one cycle past a flag or enable clear.
// R25: Sixteen-bit compare, one clocked comparison; the code also compares unclocked for periodic, time-out, single-shot.
package evtcs_pkg;

  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [2:0] PRESC_DIV1 = 3'h0;
  localparam logic [2:0] PRESC_DIV2 = 3'h1;
  localparam logic [2:0] PRESC_COMPANION = 3'h2;
  localparam logic [0:0] PRESC_DIV2_LAST = 1'h1;

  typedef enum logic [2:0] {
    EVTCS_MODE_PERIODIC = 3'b000,
    EVTCS_MODE_TIMEOUT = 3'b001,
    EVTCS_MODE_CAPTURE = 3'b010,
    EVTCS_MODE_FREQ = 3'b011,
    EVTCS_MODE_PULSE = 3'b100,
    EVTCS_MODE_FREQPW = 3'b101,
    EVTCS_MODE_SINGLE = 3'b110
  } evtcs_mode_t;

  typedef struct packed {
    logic enable;
    logic [2:0] clock_source_select;
    evtcs_mode_t mode;
    logic compare_output_enable;
    logic event_input_enable;
    logic edge_select;
    logic interrupt_enable;
  } evtcs_cfg_t;

  typedef struct packed {
    logic count_write;
    logic [15:0] count_wdata;
    logic compare_write;
    logic [15:0] compare_wdata;
    logic compare_low_read;
    logic count_read;
    logic run_write;
    logic run_wdata;
    logic flag_clear;
  } evtcs_sw_t;

endpackage

// [hdl/evtcs_tick.sv]
`timescale 1ns/1ps
module evtcs_tick (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Selection
  input wire logic enable_i,
  input wire logic [2:0] sel_i,
  input wire logic companion_tick_i,
  // Tick out
  output logic tick_o
);
  logic [0:0] div_reg;

  always_ff @(posedge clk_i) begin
    if (!resetn_i || !enable_i) begin
      div_reg <= 1'h0;
    end else begin
      div_reg <= div_reg + 1'h1;
    end
  end

  always_comb begin
    case (sel_i) // [R2]
      evtcs_pkg::PRESC_DIV1: tick_o = enable_i;
      evtcs_pkg::PRESC_DIV2:
        tick_o = enable_i && (div_reg == evtcs_pkg::PRESC_DIV2_LAST);
      evtcs_pkg::PRESC_COMPANION: tick_o = enable_i && companion_tick_i;
      default: tick_o = enable_i;
    endcase
  end
endmodule

// [hdl/evtcs_edge.sv]
`timescale 1ns/1ps
module evtcs_edge (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Event level from the routing network
  input wire logic event_i,
  // Detected edges
  output logic rise_o,
  output logic fall_o
);
  // The first stage is read only by the second stage.
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= event_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign rise_o = s2_reg && !s3_reg;
  assign fall_o = !s2_reg && s3_reg;
endmodule

// [hdl/evtcs_timer.sv]
`timescale 1ns/1ps
module evtcs_timer (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  // Configuration and software access
  input wire evtcs_pkg::evtcs_cfg_t CFG_I,
  input wire evtcs_pkg::evtcs_sw_t SW_I,
  // Companion timer and events
  input wire logic COMPANION_TICK_I,
  input wire logic EVENT_I,
  input wire logic PORT_OUT_I,
  // Status
  output logic [15:0] COUNT_O,
  output logic [15:0] COMPARE_O,
  output logic RUN_O,
  output logic FLAG_O,
  output logic IRQ_O,
  output logic EVENT_O,
  output logic PIN_O
);
  localparam logic [15:0] BOT = evtcs_pkg::CNT_BOTTOM;

  logic tick;
  logic rise;
  logic fall;
  logic [15:0] count_reg;
  logic [15:0] compare_reg;
  logic run_reg;
  logic flag_reg;
  logic irq_reg;
  logic event_reg;
  logic pin_reg;
  logic wave_reg;
  logic match_reg;
  logic phase_reg;
  logic hold_reg;
  logic [1:0] trig_reg;
  logic en_d_reg;
  logic ev_rise;
  logic ev_fall;
  logic start_edge;
  logic stop_edge;
  logic set_flag;
  logic capture;
  logic restart;
  logic start_run;
  logic stop_run;
  logic trig;
  evtcs_pkg::evtcs_mode_t mode;

  function automatic logic [15:0] incr(input logic [15:0] v);
    incr = v + evtcs_pkg::CNT_ONE; // [R1]
  endfunction

  evtcs_tick u_tick (
    .clk_i(CORE_CLK_I),
    .resetn_i(RESETN_I),
    .enable_i(CFG_I.enable),
    .sel_i(CFG_I.clock_source_select),
    .companion_tick_i(COMPANION_TICK_I),
    .tick_o(tick)
  );

  // The event pin passes two flops inside the edge detector first.
  evtcs_edge u_edge (
    .clk_i(CORE_CLK_I),
    .resetn_i(RESETN_I),
    .event_i(EVENT_I),
    .rise_o(rise),
    .fall_o(fall)
  );

  assign mode = CFG_I.mode;
  // Events are gated so a disabled timer cannot be disturbed by them.
  assign ev_rise = rise && CFG_I.event_input_enable && CFG_I.enable; // [R23]
  assign ev_fall = fall && CFG_I.event_input_enable && CFG_I.enable; // [R23]
  assign start_edge = CFG_I.edge_select ? ev_fall : ev_rise; // [R7]
  assign stop_edge = CFG_I.edge_select ? ev_rise : ev_fall; // [R7]
  assign trig = ev_rise || (CFG_I.edge_select && ev_fall); // [R21]

  // This registered comparison feeds only the waveform outside single-shot mode; mode logic compares unregistered.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= (count_reg == compare_reg); // [R25]
    end
  end

  always_comb begin
    set_flag = 1'b0;
    capture = 1'b0;
    restart = 1'b0;
    start_run = 1'b0;
    stop_run = 1'b0;
    case (mode)
      evtcs_pkg::EVTCS_MODE_PERIODIC: begin
        if (tick && count_reg == compare_reg) begin
          set_flag = 1'b1; // [R5]
          restart = 1'b1; // [R5]
        end
      end
      evtcs_pkg::EVTCS_MODE_TIMEOUT: begin
        if (start_edge && !run_reg) begin
          start_run = 1'b1; // [R7]
          restart = 1'b1;
        end else if (stop_edge && run_reg) begin
          stop_run = 1'b1; // [R9]
        end
        if (run_reg && tick && count_reg == compare_reg) begin
          set_flag = 1'b1; // [R8]
        end
      end
      evtcs_pkg::EVTCS_MODE_CAPTURE: begin
        if (CFG_I.edge_select ? ev_fall : ev_rise) begin
          capture = 1'b1; // [R10]
          set_flag = 1'b1; // [R10]
        end
      end
      evtcs_pkg::EVTCS_MODE_FREQ: begin
        if (CFG_I.edge_select ? ev_fall : ev_rise) begin
          capture = 1'b1; // [R13]
          restart = 1'b1; // [R13]
          set_flag = 1'b1;
        end
      end
      evtcs_pkg::EVTCS_MODE_PULSE: begin
        if (ev_rise) begin
          restart = 1'b1; // [R14]
        end else if (ev_fall) begin
          capture = 1'b1; // [R14]
          set_flag = 1'b1; // [R14]
        end
      end
      evtcs_pkg::EVTCS_MODE_FREQPW: begin
        if (ev_rise && !run_reg && !phase_reg && !flag_reg) begin
          start_run = 1'b1; // [R16]
          restart = 1'b1;
        end else if (ev_fall && run_reg && !phase_reg) begin
          capture = 1'b1; // [R16]
        end else if (ev_rise && run_reg && phase_reg) begin
          stop_run = 1'b1; // [R16]
          set_flag = 1'b1; // [R16]
        end
      end
      evtcs_pkg::EVTCS_MODE_SINGLE: begin
        if (run_reg && tick && count_reg == compare_reg) begin
          stop_run = 1'b1; // [R19]
        end
      end
      default: begin
      end
    endcase
  end

  // Single-shot trigger passes a two-cycle delay before it sets run; the pin rises two clocks later.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      trig_reg <= 2'b00;
    end else if (mode == evtcs_pkg::EVTCS_MODE_SINGLE) begin
      trig_reg <= {trig_reg[0], trig && !run_reg && !hold_reg}; // [R19]
    end else begin
      trig_reg <= 2'b00;
    end
  end

  // Hold keeps the output low for one tick after a stop.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      hold_reg <= 1'b0;
    end else if (stop_run && mode == evtcs_pkg::EVTCS_MODE_SINGLE) begin
      hold_reg <= 1'b1; // [R19]
    end else if (tick) begin
      hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= CFG_I.enable;
    end
  end

  // A frozen time-out ignores run writes; only a new start edge revives it.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      run_reg <= 1'b0;
    end else if (!CFG_I.enable) begin
      run_reg <= 1'b0;
    end else if (mode == evtcs_pkg::EVTCS_MODE_SINGLE &&
                 CFG_I.enable && !en_d_reg) begin
      run_reg <= 1'b1; // [R22]
    end else if (trig_reg[1]) begin
      run_reg <= 1'b1; // [R20]
    end else if (stop_run) begin
      run_reg <= 1'b0;
    end else if (start_run) begin
      run_reg <= 1'b1;
    end else if (SW_I.run_write && !(mode == evtcs_pkg::EVTCS_MODE_TIMEOUT
                 && !run_reg)) begin
      run_reg <= SW_I.run_wdata; // [R9]
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      phase_reg <= 1'b0;
    end else if (mode != evtcs_pkg::EVTCS_MODE_FREQPW || stop_run) begin
      phase_reg <= 1'b0;
    end else if (capture) begin
      phase_reg <= 1'b1;
    end
  end

  // A software write wins over every hardware update of the count.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      count_reg <= BOT;
    end else if (SW_I.count_write) begin
      count_reg <= SW_I.count_wdata;
    end else if (trig_reg[1] || restart) begin
      count_reg <= BOT; // [R18]
    end else if (tick && !stop_run) begin
      case (mode)
        evtcs_pkg::EVTCS_MODE_TIMEOUT,
        evtcs_pkg::EVTCS_MODE_FREQPW,
        evtcs_pkg::EVTCS_MODE_SINGLE: begin
          if (run_reg) begin
            count_reg <= incr(count_reg); // [R4]
          end
        end
        default: count_reg <= incr(count_reg); // [R6]
      endcase
    end
  end

  // A capture wins over a compare write that lands in the same cycle.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      compare_reg <= BOT;
    end else if (capture) begin
      compare_reg <= count_reg;
    end else if (SW_I.compare_write) begin
      compare_reg <= SW_I.compare_wdata;
    end
  end

  // A new flag event wins over a clear in the same cycle.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      flag_reg <= 1'b0;
    end else if (set_flag) begin
      flag_reg <= 1'b1;
    end else if (SW_I.flag_clear) begin
      flag_reg <= 1'b0;
    end else if (SW_I.compare_low_read && mode != evtcs_pkg::EVTCS_MODE_PERIODIC
                 && mode != evtcs_pkg::EVTCS_MODE_TIMEOUT
                 && mode != evtcs_pkg::EVTCS_MODE_SINGLE) begin
      flag_reg <= 1'b0; // [R11]
    end
  end

  // The set term lets the request rise with the flag; after a clear it
  // still stands for one more cycle, the cost of a registered output.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      irq_reg <= 1'b0;
      event_reg <= 1'b0;
    end else begin
      irq_reg <= (flag_reg || set_flag) && CFG_I.interrupt_enable; // [R24]
      event_reg <= set_flag; // [R5]
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      wave_reg <= 1'b0;
    end else if (mode == evtcs_pkg::EVTCS_MODE_SINGLE) begin
      wave_reg <= run_reg && !stop_run && !hold_reg; // [R18]
    end else begin
      wave_reg <= match_reg;
    end
  end

  // The pin gets its own flop so the top output never sees a glitch.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= CFG_I.compare_output_enable ? wave_reg : PORT_OUT_I; // [R3]
    end
  end

  assign COUNT_O = count_reg;
  assign COMPARE_O = compare_reg;
  assign RUN_O = run_reg;
  assign FLAG_O = flag_reg;
  assign IRQ_O = irq_reg;
  assign EVENT_O = event_reg;
  assign PIN_O = pin_reg;
endmodule

// [verif/evtcs_timer_assertions.sv]
`timescale 1ns/1ps
module evtcs_timer_chk (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  // Inputs
  input wire evtcs_pkg::evtcs_cfg_t CFG_I,
  input wire evtcs_pkg::evtcs_sw_t SW_I,
  input wire logic PORT_OUT_I,
  // Outputs
  input wire logic [15:0] COUNT_O,
  input wire logic [15:0] COMPARE_O,
  input wire logic RUN_O,
  input wire logic FLAG_O,
  input wire logic IRQ_O,
  input wire logic EVENT_O,
  input wire logic PIN_O
);
  logic en_reg;
  logic per;
  logic ticking;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // The tick path may lag enable by a cycle, so only steady runs count.
  always_ff @(posedge CORE_CLK_I) begin
    en_reg <= RESETN_I && CFG_I.enable;
  end
  assign ticking = en_reg && CFG_I.enable && !SW_I.count_write &&
    CFG_I.clock_source_select == evtcs_pkg::PRESC_DIV1;
  assign per = ticking && !SW_I.compare_write &&
    CFG_I.mode == evtcs_pkg::EVTCS_MODE_PERIODIC;
  sequence shot_hit;
    ticking && CFG_I.mode == evtcs_pkg::EVTCS_MODE_SINGLE && RUN_O &&
      COUNT_O == COMPARE_O;
  endsequence
  sequence shot_hold;
    !RUN_O ##1 !RUN_O;
  endsequence
  irq_follows_a: assert property (
    FLAG_O && CFG_I.interrupt_enable |=> IRQ_O) else $error("irq missing");
  // The request may stand one cycle past a clear, so two clear cycles count.
  irq_drops_a: assert property (!FLAG_O ##1 !FLAG_O |-> !IRQ_O)
    else $error("irq stuck");
  flag_event_a: assert property ($rose(FLAG_O) |-> EVENT_O)
    else $error("event missing");
  port_pin_a: assert property (!CFG_I.compare_output_enable |=>
    PIN_O == $past(PORT_OUT_I)) else $error("pin wrong");
  period_end_a: assert property (per && COUNT_O == COMPARE_O |=>
    COUNT_O == evtcs_pkg::CNT_BOTTOM && FLAG_O) else $error("no restart");
  max_wrap_a: assert property (
    per && COUNT_O == evtcs_pkg::CNT_MAX |=>
    COUNT_O == evtcs_pkg::CNT_BOTTOM) else $error("no wrap");
  count_step_a: assert property (per && COUNT_O != COMPARE_O &&
    COUNT_O != evtcs_pkg::CNT_MAX |=> COUNT_O == $past(COUNT_O) + 16'h0001)
    else $error("bad step");
  low_read_a: assert property (
    CFG_I.mode == evtcs_pkg::EVTCS_MODE_CAPTURE &&
    SW_I.compare_low_read && !CFG_I.event_input_enable |=> !FLAG_O)
    else $error("flag kept");
  idle_capture_a: assert property (!CFG_I.event_input_enable &&
    CFG_I.mode == evtcs_pkg::EVTCS_MODE_CAPTURE && !SW_I.compare_write
    |=> $stable(COMPARE_O)) else $error("capture moved");
  shot_stop_a: assert property (shot_hit |=> shot_hold)
    else $error("shot kept running");
endmodule

bind evtcs_timer evtcs_timer_chk evtcs_timer_chk_inst (
  .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .CFG_I(CFG_I), .SW_I(SW_I),
  .PORT_OUT_I(PORT_OUT_I), .COUNT_O(COUNT_O), .COMPARE_O(COMPARE_O),
  .RUN_O(RUN_O), .FLAG_O(FLAG_O), .IRQ_O(IRQ_O), .EVENT_O(EVENT_O),
  .PIN_O(PIN_O)
);

// [verif/evtcs_evsrc.sv]
`timescale 1ns/1ps
module evtcs_evsrc (
  // Clock
  input wire logic clk_i,
  // Companion tick spacing
  input wire logic [3:0] div_i,
  // Event level and companion tick
  output logic level_o,
  output logic tick_o
);
  logic [3:0] cnt_reg = 4'h0;
  initial level_o = 1'b0;
  // The companion tick is one clock wide.
  always @(posedge clk_i) begin
    cnt_reg <= (cnt_reg >= div_i) ? 4'h0 : cnt_reg + 4'h1;
  end
  assign tick_o = (cnt_reg == div_i);
  // Callers keep gap at two or more, so edges never crowd.
  task automatic drive(input logic v, input int gap);
    repeat (gap) @(posedge clk_i);
    #1 level_o = v;
  endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic resetn;
  logic port_out;
  logic [3:0] div;
  logic tick;
  logic evt;
  logic [15:0] count;
  logic [15:0] compare;
  logic run;
  logic flag;
  logic irq;
  logic ev_out;
  logic pin;
  logic [15:0] held;
  evtcs_pkg::evtcs_cfg_t cfg;
  evtcs_pkg::evtcs_sw_t sw;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;

  evtcs_timer evtcs_timer_inst (
    .CORE_CLK_I(clk), .RESETN_I(resetn), .CFG_I(cfg), .SW_I(sw),
    .COMPANION_TICK_I(tick), .EVENT_I(evt), .PORT_OUT_I(port_out),
    .COUNT_O(count), .COMPARE_O(compare), .RUN_O(run), .FLAG_O(flag),
    .IRQ_O(irq), .EVENT_O(ev_out), .PIN_O(pin)
  );
  evtcs_evsrc evtcs_evsrc_inst (
    .clk_i(clk), .div_i(div), .level_o(evt), .tick_o(tick)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] g, lo, hi);
    n_checks++;
    if ((g >= lo) !== 1'b1 || (g <= hi) !== 1'b1) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, lo);
    end
  endtask

  // Bits of k: count write, compare write, low read, flag clear.
  task automatic swp(input logic [3:0] k, input logic [15:0] v);
    sw.count_write = k[0];
    sw.count_wdata = v;
    sw.compare_write = k[1];
    sw.compare_wdata = v;
    sw.compare_low_read = k[2];
    sw.flag_clear = k[3];
    step(1);
    sw = '0;
  endtask

  task automatic wait1(ref logic s);
    for (int i = 0; i < 40 && s !== 1'b1; i++) step(1);
  endtask

  task automatic go(input evtcs_pkg::evtcs_mode_t m);
    cfg.enable = 1'b0;
    step(1);
    cfg.mode = m;
    cfg.enable = 1'b1;
  endtask

  task automatic rate(input logic [2:0] s, input logic [15:0] lo, hi);
    cfg.enable = 1'b0;
    cfg.clock_source_select = s;
    swp(4'h1, 16'h0000);
    swp(4'h2, 16'hFFFF);
    cfg.enable = 1'b1;
    step(40);
    chk(count, lo, hi);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    cfg = '0;
    sw = '0;
    port_out = 1'b1;
    div = 4'h3;
    resetn = 1'b0;
    step(20);
    resetn = 1'b1;
    chk(count, 16'h0000, 16'h0000);
    step(2);
    chk(16'(pin), 16'h0001, 16'h0001);
    port_out = 1'b0;
    step(2);
    chk(16'(pin), 16'h0000, 16'h0000);
    cfg.interrupt_enable = 1'b1;
    swp(4'h2, 16'h0003);
    cfg.enable = 1'b1;
    wait1(flag);
    chk(count, 16'h0000, 16'h0000);
    chk(16'({irq, ev_out}), 16'h0003, 16'h0003);
    step(1);
    chk(16'({irq, ev_out}), 16'h0002, 16'h0002);
    cfg.enable = 1'b0;
    swp(4'h9, 16'hFFFE);
    step(1);
    chk(16'(irq), 16'h0000, 16'h0000);
    cfg.enable = 1'b1;
    step(3);
    chk(count, 16'h0000, 16'h0001);
    $display("periodic test done");
    rate(evtcs_pkg::PRESC_DIV2, 16'h0012, 16'h0014);
    rate(evtcs_pkg::PRESC_COMPANION, 16'h0008, 16'h000A);
    cfg.clock_source_select = evtcs_pkg::PRESC_DIV1;
    $display("clock test done");
    cfg.event_input_enable = 1'b1;
    go(evtcs_pkg::EVTCS_MODE_CAPTURE);
    swp(4'h9, 16'h0000);
    evtcs_evsrc_inst.drive(1'b1, 10);
    wait1(flag);
    chk(count - compare, 16'h0001, 16'h0001);
    cfg.event_input_enable = 1'b0;
    swp(4'h4, 16'h0000);
    chk(16'(flag), 16'h0000, 16'h0000);
    evtcs_evsrc_inst.drive(1'b0, 4);
    evtcs_evsrc_inst.drive(1'b1, 4);
    step(6);
    chk(16'(flag), 16'h0000, 16'h0000);
    $display("capture test done");
    cfg.event_input_enable = 1'b1;
    go(evtcs_pkg::EVTCS_MODE_FREQ);
    evtcs_evsrc_inst.drive(1'b0, 4);
    evtcs_evsrc_inst.drive(1'b1, 4);
    evtcs_evsrc_inst.drive(1'b0, 10);
    evtcs_evsrc_inst.drive(1'b1, 10);
    step(6);
    chk(compare, 16'h0013, 16'h0014);
    swp(4'h4, 16'h0000);
    go(evtcs_pkg::EVTCS_MODE_PULSE);
    evtcs_evsrc_inst.drive(1'b0, 4);
    evtcs_evsrc_inst.drive(1'b1, 4);
    evtcs_evsrc_inst.drive(1'b0, 12);
    step(6);
    chk(compare, 16'h000B, 16'h000C);
    chk(16'(flag), 16'h0001, 16'h0001);
    swp(4'h4, 16'h0000);
    go(evtcs_pkg::EVTCS_MODE_FREQPW);
    evtcs_evsrc_inst.drive(1'b1, 4);
    evtcs_evsrc_inst.drive(1'b0, 8);
    evtcs_evsrc_inst.drive(1'b1, 8);
    step(6);
    chk(count, 16'h000E, 16'h0010);
    chk(compare, 16'h0007, 16'h0008);
    $display("measure test done");
    go(evtcs_pkg::EVTCS_MODE_TIMEOUT);
    swp(4'hA, 16'h0006);
    evtcs_evsrc_inst.drive(1'b0, 4);
    evtcs_evsrc_inst.drive(1'b1, 2);
    step(14);
    chk(16'(flag), 16'h0001, 16'h0001);
    evtcs_evsrc_inst.drive(1'b0, 2);
    step(4);
    held = count;
    sw.run_write = 1'b1;
    sw.run_wdata = 1'b1;
    step(1);
    sw = '0;
    step(3);
    chk(count, held, held);
    chk(16'(run), 16'h0000, 16'h0000);
    $display("timeout test done");
    cfg.enable = 1'b0;
    cfg.mode = evtcs_pkg::EVTCS_MODE_SINGLE;
    cfg.compare_output_enable = 1'b1;
    swp(4'h2, 16'h0005);
    swp(4'h9, 16'h0005);
    cfg.enable = 1'b1;
    step(6);
    chk(16'({run, pin}), 16'h0000, 16'h0000);
    evtcs_evsrc_inst.drive(1'b1, 2);
    wait1(run);
    step(2);
    chk(16'({run, pin}), 16'h0003, 16'h0003);
    step(12);
    chk(16'({run, pin}), 16'h0000, 16'h0000);
    evtcs_evsrc_inst.drive(1'b0, 2);
    step(8);
    chk(16'(run), 16'h0000, 16'h0000);
    cfg.edge_select = 1'b1;
    evtcs_evsrc_inst.drive(1'b1, 2);
    step(14);
    evtcs_evsrc_inst.drive(1'b0, 2);
    wait1(run);
    chk(16'(run), 16'h0001, 16'h0001);
    $display("single shot test done");
    tally_and_finish();
  end
endmodule
